// ---- bmai_master.sv ----
// bmai_master.sv: board end: requester, grant chain, optional arbiter,
// transfer termination and interrupt encoding
// assumes: one clock; backplane inputs asynchronous; bench resolves wires
//
// Operation
// - low acknowledge ends transfer successfully
// - low bus error ends transfer as failed
// - request only on selected level, open-collector
// - watch request lines, own line excluded while requesting or master
// - on-board arbiter takes level-3 request
// - own grant only from selected level
// - other grant levels pass straight through
// - enabled arbiter drives level-3 grant, totem-pole
// - selected grant output passes chain onward
// - unrequested grant forwarded while grant low
// - drive busy low while master
// - bus clear may raise an interrupt
// - seven interrupt inputs, level 7 highest
// - acknowledge low during vector fetch cycle
// - acknowledge chain input passes straight through
// - power-fail input raises non-maskable interrupt
`timescale 1ns/1ns
module bmai_master
  import bmai_pkg::*;
#(
  parameter logic [1:0] REQ_LEVEL = 2'h0
)(
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_in,
  // link
  bmai_bus_if.device bus,
  // jumper options
  input wire logic arb_enable_in,
  input wire logic ror_enable_in,
  input wire logic clr_irq_enable_in,
  // local bus side
  input wire logic want_bus_in,
  input wire logic cycle_active_in,
  input wire logic vector_fetch_in,
  output logic bus_owned_out,
  output logic xfer_done_out,
  output logic xfer_err_out,
  output logic [2:0] irq_level_out,
  output logic nmi_out,
  output logic clr_irq_out
);
  localparam int NL = `BMAI_NUM_LEVELS;
  localparam int NI = `BMAI_NUM_IRQ;

  // highest active interrupt level, 0 when none
  function automatic logic [2:0] bmai_prio(input logic [7:1] act);
    logic [2:0] lvl;
    lvl = 3'h0;
    for (int i = 1; i <= NI; i++) begin
      if (act[i]) begin
        lvl = 3'(i);
      end
    end
    return lvl;
  endfunction : bmai_prio

  typedef struct packed {
    logic [1:0] ack_s;
    logic [1:0] err_s;
    logic [3:0] req_s1;
    logic [3:0] req_s2;
    logic [3:0] gnt_s1;
    logic [3:0] gnt_s2;
    logic [1:0] busy_s;
    logic [1:0] clr_s;
    logic [6:0] irq_s1;
    logic [6:0] irq_s2;
    logic [1:0] acf_s;
    bmai_req_st_t req_st;
    bmai_xfer_t xfer;
    logic arb_gnt;
    logic [2:0] irq_lvl;
    logic nmi;
    logic clr_irq;
  } bmai_m_st_t;

  bmai_m_st_t st_q;
  bmai_m_st_t st_d;

  logic my_gnt;
  logic my_req_pending;
  logic others_req;

  // second stage only is read by logic
  assign my_gnt = st_q.gnt_s2[REQ_LEVEL];
  assign my_req_pending = (st_q.req_st == BMAI_REQ_WAIT);

  always_comb begin
    logic [3:0] req_mask;
    req_mask = 4'h0;
    req_mask[REQ_LEVEL] = (st_q.req_st != BMAI_REQ_IDLE) &&
                          (st_q.req_st != BMAI_REQ_PASS);
    // own line is also pulled by us, so it is excluded
    others_req = |(st_q.req_s2 & ~req_mask);
  end

  always_comb begin
    st_d = st_q;
    // two-stage synchronisers for every backplane input except the iack chain input
    st_d.ack_s = {st_q.ack_s[0], ~bus.xfer_ack_n};
    st_d.err_s = {st_q.err_s[0], ~bus.xfer_err_n};
    st_d.req_s1 = ~bus.bus_req_n;
    st_d.req_s2 = st_q.req_s1;
    st_d.gnt_s1 = ~bus.grant_in_n;
    st_d.gnt_s2 = st_q.gnt_s1;
    st_d.busy_s = {st_q.busy_s[0], ~bus.busy_n};
    st_d.clr_s = {st_q.clr_s[0], ~bus.bus_clear_n};
    st_d.irq_s1 = ~bus.irq_n;
    st_d.irq_s2 = st_q.irq_s1;
    st_d.acf_s = {st_q.acf_s[0], ~bus.acfail_n};

    // transfer termination; error takes precedence if both arrive
    st_d.xfer = BMAI_XFER_NONE;
    if (cycle_active_in && st_q.err_s[1]) begin
      st_d.xfer = BMAI_XFER_ERR;
    end else if (cycle_active_in && st_q.ack_s[1]) begin
      st_d.xfer = BMAI_XFER_OK;
    end

    case (st_q.req_st)
      BMAI_REQ_IDLE: begin
        if (my_gnt && !want_bus_in) begin
          st_d.req_st = BMAI_REQ_PASS;
        end else if (want_bus_in) begin
          st_d.req_st = BMAI_REQ_WAIT;
        end
      end
      BMAI_REQ_WAIT: begin
        // take the bus only once the previous master let go
        if (my_gnt && !st_q.busy_s[1]) begin
          st_d.req_st = BMAI_REQ_OWN;
        end
      end
      BMAI_REQ_OWN: begin
        // release when done, or on another request in ror mode
        if (!cycle_active_in &&
            (!want_bus_in || (ror_enable_in && others_req))) begin
          st_d.req_st = BMAI_REQ_IDLE;
        end
      end
      BMAI_REQ_PASS: begin
        // held as long as the grant input stays low
        if (!my_gnt) begin
          st_d.req_st = BMAI_REQ_IDLE;
        end
      end
      default: st_d.req_st = BMAI_REQ_IDLE;
    endcase

    // level-3 arbiter: grant when requested and the bus is free
    if (!arb_enable_in) begin
      st_d.arb_gnt = 1'b0;
    end else if (st_q.arb_gnt) begin
      st_d.arb_gnt = st_q.req_s2[`BMAI_ARB_LEVEL] || !st_q.busy_s[1];
      if (st_q.busy_s[1] && !st_q.req_s2[`BMAI_ARB_LEVEL]) begin
        st_d.arb_gnt = 1'b0;
      end
    end else begin
      st_d.arb_gnt = st_q.req_s2[`BMAI_ARB_LEVEL] && !st_q.busy_s[1];
    end

    st_d.irq_lvl = bmai_prio(st_q.irq_s2);
    st_d.nmi = st_q.acf_s[1];
    st_d.clr_irq = clr_irq_enable_in && st_q.clr_s[1];
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      st_q <= '0;
      st_q.req_st <= BMAI_REQ_IDLE;
      st_q.xfer <= BMAI_XFER_NONE;
    end else begin
      st_q <= st_d;
    end
  end

  // request: drive only the selected line, open-collector
  generate
    for (genvar g = 0; g < NL; g++) begin : g_lvl
      if (g == REQ_LEVEL) begin : g_own
        assign bus.bus_req_o_n_dev[g] = 1'b0;
        assign bus.bus_req_oe_n_dev[g] = ~my_req_pending;
        assign bus.grant_out_n[g] =
          ~(st_q.req_st == BMAI_REQ_PASS);
      end else begin : g_pass
        assign bus.bus_req_o_n_dev[g] = 1'b1;
        assign bus.bus_req_oe_n_dev[g] = 1'b1;
        // straight wire, no logic in the daisy chain
        assign bus.grant_out_n[g] = bus.grant_in_n[g];
      end
    end
  endgenerate

  // arbiter drives the chain head actively in both levels
  assign bus.arb_grant_o_n = ~st_q.arb_gnt;
  assign bus.arb_grant_oe_n = ~arb_enable_in;
  assign bus.busy_o_n_dev = 1'b0;
  assign bus.busy_oe_n_dev = ~(st_q.req_st == BMAI_REQ_OWN);
  // vector fetch is qualified by the active cycle
  assign bus.iack_n = ~(vector_fetch_in & cycle_active_in);
  assign bus.iack_chain_out_n = bus.iack_chain_in_n;

  assign bus_owned_out = (st_q.req_st == BMAI_REQ_OWN);
  assign xfer_done_out = (st_q.xfer == BMAI_XFER_OK);
  assign xfer_err_out = (st_q.xfer == BMAI_XFER_ERR);
  assign irq_level_out = st_q.irq_lvl;
  assign nmi_out = st_q.nmi;
  assign clr_irq_out = st_q.clr_irq;
endmodule : bmai_master

// ---- bmai_cfg.svh ----
// bmai_cfg.svh: numeric constants of the backplane master/arbitration block
// assumes: included by bare name; 50 MHz reference clock
`ifndef BMAI_CFG_SVH
`define BMAI_CFG_SVH
`define BMAI_CLK_MHZ 50
`define BMAI_ACFAIL_LEAD_MS 10
// cycles of warning the supply gives before rails may drift
`define BMAI_ACFAIL_LEAD_CYC (`BMAI_ACFAIL_LEAD_MS * 1000 * `BMAI_CLK_MHZ)
`define BMAI_ARB_LEVEL 3
`define BMAI_NUM_LEVELS 4
`define BMAI_NUM_IRQ 7
`endif

// ---- bmai_pkg.sv ----
// bmai_pkg.sv: shared types of the backplane master/arbitration block
// assumes: bmai_cfg.svh on the include path
`include "bmai_cfg.svh"
package bmai_pkg;
  typedef enum logic [1:0] {
    BMAI_REQ_IDLE,
    BMAI_REQ_WAIT,
    BMAI_REQ_OWN,
    BMAI_REQ_PASS
  } bmai_req_st_t;

  typedef enum logic [1:0] {
    BMAI_XFER_NONE,
    BMAI_XFER_OK,
    BMAI_XFER_ERR
  } bmai_xfer_t;
endpackage : bmai_pkg

// ---- bmai_bus_if.sv ----
// bmai_bus_if.sv: backplane arbitration, termination and interrupt wires
// assumes: active-low levels; open-collector lines resolved by the bench
`timescale 1ns/1ns
interface bmai_bus_if;
  // open-collector request lines: output value, enable (low = driving)
  logic [3:0] bus_req_o_n_dev;
  logic [3:0] bus_req_oe_n_dev;
  logic [3:0] bus_req_n;
  // grant daisy chain
  logic [3:0] grant_in_n;
  logic [3:0] grant_out_n;
  logic arb_grant_o_n;
  logic arb_grant_oe_n;
  // busy, open-collector
  logic busy_o_n_dev;
  logic busy_oe_n_dev;
  logic busy_n;
  logic bus_clear_n;
  // transfer termination
  logic xfer_ack_n;
  logic xfer_err_n;
  // interrupts
  logic [7:1] irq_n;
  logic iack_n;
  logic iack_chain_in_n;
  logic iack_chain_out_n;
  logic acfail_n;

  modport device (
    output bus_req_o_n_dev, bus_req_oe_n_dev, grant_out_n,
    output arb_grant_o_n, arb_grant_oe_n, busy_o_n_dev, busy_oe_n_dev,
    output iack_n, iack_chain_out_n,
    input bus_req_n, grant_in_n, busy_n, bus_clear_n,
    input xfer_ack_n, xfer_err_n, irq_n, iack_chain_in_n, acfail_n
  );
  modport backplane (
    input bus_req_o_n_dev, bus_req_oe_n_dev, grant_out_n,
    input arb_grant_o_n, arb_grant_oe_n, busy_o_n_dev, busy_oe_n_dev,
    input iack_n, iack_chain_out_n, bus_req_n, busy_n,
    output grant_in_n, bus_clear_n, xfer_ack_n, xfer_err_n,
    output irq_n, iack_chain_in_n, acfail_n
  );
endinterface : bmai_bus_if

// ---- bmai_backplane.sv ----
// bmai_backplane.sv: far end: slave answers, interrupt sources, supply
// assumes: one clock; a level-sensitive slave that answers each strobe
`timescale 1ns/1ns
module bmai_backplane
  import bmai_pkg::*;
(
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_in,
  // link
  bmai_bus_if.backplane bus,
  // user side
  input wire logic slave_strobe_in,
  input wire logic slave_fail_in,
  input wire logic [3:0] arb_grant_in,
  input wire logic bus_clear_in,
  input wire logic [7:1] irq_in,
  input wire logic power_fail_in,
  input wire logic iack_chain_in,
  output logic busy_seen_out,
  output logic iack_seen_out
);
  typedef struct packed {
    logic ack_n;
    logic err_n;
    logic [3:0] grant_n;
    logic clr_n;
    logic [7:1] irq_n;
    logic acfail_n;
    logic iack_chain_n;
    logic busy_seen;
    logic iack_seen;
  } bmai_bp_st_t;

  bmai_bp_st_t st_q;
  bmai_bp_st_t st_d;

  always_comb begin
    st_d = st_q;
    // one answer per strobe: good or failed, never both
    st_d.ack_n = ~(slave_strobe_in & ~slave_fail_in);
    st_d.err_n = ~(slave_strobe_in & slave_fail_in);
    st_d.grant_n = ~arb_grant_in;
    st_d.clr_n = ~bus_clear_in;
    st_d.irq_n = ~irq_in;
    // supply warns ahead of rail loss
    st_d.acfail_n = ~power_fail_in;
    st_d.iack_chain_n = ~iack_chain_in;
    st_d.busy_seen = ~bus.busy_n;
    st_d.iack_seen = ~bus.iack_chain_out_n;
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      st_q <= '{ack_n: 1'b1, err_n: 1'b1, grant_n: 4'hF, clr_n: 1'b1,
                irq_n: 7'h7F, acfail_n: 1'b1, iack_chain_n: 1'b1,
                busy_seen: 1'b0, iack_seen: 1'b0};
    end else begin
      st_q <= st_d;
    end
  end

  assign bus.xfer_ack_n = st_q.ack_n;
  assign bus.xfer_err_n = st_q.err_n;
  // an enabled on-board arbiter heads the level-3 chain itself
  assign bus.grant_in_n = {bus.arb_grant_oe_n ? st_q.grant_n[3]
                           : bus.arb_grant_o_n, st_q.grant_n[2:0]};
  assign bus.bus_clear_n = st_q.clr_n;
  assign bus.irq_n = st_q.irq_n;
  assign bus.acfail_n = st_q.acfail_n;
  assign bus.iack_chain_in_n = st_q.iack_chain_n;
  assign busy_seen_out = st_q.busy_seen;
  assign iack_seen_out = st_q.iack_seen;
endmodule : bmai_backplane

// ---- bmai_link_checker.sv ----
// bmai_link_checker.sv: assertions on the arbitration and chain wires
// assumes: sees the interface wires; REQ_LEVEL matches the board end
`timescale 1ns/1ns
module bmai_link_checker #(
  parameter logic [1:0] REQ_LEVEL = 2'h0
)(
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_in,
  // requests and busy
  input wire logic [3:0] bus_req_o_n_dev,
  input wire logic [3:0] bus_req_oe_n_dev,
  input wire logic busy_o_n_dev,
  input wire logic busy_oe_n_dev,
  input wire logic [3:0] bus_req_n,
  // on-board arbiter
  input wire logic arb_grant_o_n,
  input wire logic arb_grant_oe_n,
  // chains
  input wire logic [3:0] grant_in_n,
  input wire logic [3:0] grant_out_n,
  input wire logic iack_chain_in_n,
  input wire logic iack_chain_out_n
);
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);
  logic [3:0] others;
  assign others = 4'hF & ~(4'h1 << REQ_LEVEL);
  a_pass_grant:
    assert property ((grant_out_n & others) == (grant_in_n & others))
      else $error("passed grant differs");
  a_iack_chain:
    assert property (iack_chain_out_n == iack_chain_in_n)
      else $error("iack chain differs");
  a_one_request:
    assert property ((bus_req_oe_n_dev & others) == others)
      else $error("request on wrong level");
  a_req_drives_low:
    assert property (!bus_req_oe_n_dev[REQ_LEVEL]
      |-> !bus_req_o_n_dev[REQ_LEVEL]) else $error("request not low");
  a_busy_drives_low:
    assert property (!busy_oe_n_dev |-> !busy_o_n_dev)
      else $error("busy not low");
  a_own_after_req:
    assert property ($fell(busy_oe_n_dev)
      |-> !$past(bus_req_oe_n_dev[REQ_LEVEL])) else $error("busy unasked");
  a_own_drops_req:
    assert property (!busy_oe_n_dev |-> bus_req_oe_n_dev[REQ_LEVEL])
      else $error("request held while owner");
  a_sel_grant_free:
    assert property (!grant_out_n[REQ_LEVEL]
      |-> busy_oe_n_dev && bus_req_oe_n_dev[REQ_LEVEL])
      else $error("grant passed while busy");
  a_sel_grant_cause:
    assert property ($fell(grant_out_n[REQ_LEVEL])
      |-> !$past(grant_in_n[REQ_LEVEL])) else $error("grant out uncaused");
  // two sync stages and the grant flop lie between request and grant
  a_arb_takes_req:
    assert property ($fell(arb_grant_o_n) |-> !$past(bus_req_n[3], 3))
      else $error("arbiter grant without level-3 request");
  a_arb_heads_chain:
    assert property (!arb_grant_oe_n |-> grant_in_n[3] == arb_grant_o_n)
      else $error("arbiter not driving chain head");
endmodule : bmai_link_checker

// ---- test_backplane_master_arbitration_interrupt.sv ----
// test_backplane_master_arbitration_interrupt.sv: both ends face to face
// assumes: open-collector wires resolved here, pull-ups otherwise
`timescale 1ns/1ns
module test_backplane_master_arbitration_interrupt;
  localparam logic [1:0] LVL = 2'h1;
  logic ref_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic want, act, vec, clr_en, strobe, fail, bclr, pf, iack_in;
  logic arb_en, ror_en;
  logic [3:0] ext_req;
  logic owned, done, err, nmi, clri, busy_seen, iack_seen;
  logic [3:0] grant;
  logic [7:1] irq;
  logic [2:0] lvl;
  logic [31:0] seed = 32'h38C5;
  int n_fail = 0;
  int num_checks = 0;
  int k, e, x;
  `define TCHK(a, b) begin num_checks++; if ((a) !== (b)) begin n_fail++; \
    $display("FAIL t=%0t got=%h exp=%h", $time, a, b); end end
  `define WAITC(c) for (k = 0; k < 30 && !(c); k++) step(1); \
    if (k == 30) begin n_fail++; report_and_stop(); end
  always #10 ref_clk_in = ~ref_clk_in;
  bmai_bus_if bus ();
  // a line is low only where some end drives it
  // other masters pull their request lines low as well
  assign bus.bus_req_n = (bus.bus_req_oe_n_dev | bus.bus_req_o_n_dev) &
                         ~ext_req;
  assign bus.busy_n = bus.busy_oe_n_dev | bus.busy_o_n_dev;
  bmai_master #(.REQ_LEVEL(LVL)) bmai_master_i (
    .ref_clk_in, .rst_in, .bus(bus.device), .arb_enable_in(arb_en),
    .ror_enable_in(ror_en), .clr_irq_enable_in(clr_en), .want_bus_in(want),
    .cycle_active_in(act), .vector_fetch_in(vec), .bus_owned_out(owned),
    .xfer_done_out(done), .xfer_err_out(err), .irq_level_out(lvl),
    .nmi_out(nmi), .clr_irq_out(clri));
  bmai_backplane bmai_backplane_i (
    .ref_clk_in, .rst_in, .bus(bus.backplane), .slave_strobe_in(strobe),
    .slave_fail_in(fail), .arb_grant_in(grant), .bus_clear_in(bclr),
    .irq_in(irq), .power_fail_in(pf), .iack_chain_in(iack_in),
    .busy_seen_out(busy_seen), .iack_seen_out(iack_seen));
  bmai_link_checker #(.REQ_LEVEL(LVL)) bmai_link_checker_i (
    .ref_clk_in, .rst_in, .bus_req_o_n_dev(bus.bus_req_o_n_dev),
    .bus_req_oe_n_dev(bus.bus_req_oe_n_dev), .busy_o_n_dev(bus.busy_o_n_dev),
    .busy_oe_n_dev(bus.busy_oe_n_dev), .grant_in_n(bus.grant_in_n),
    .grant_out_n(bus.grant_out_n), .iack_chain_in_n(bus.iack_chain_in_n),
    .iack_chain_out_n(bus.iack_chain_out_n), .bus_req_n(bus.bus_req_n),
    .arb_grant_o_n(bus.arb_grant_o_n), .arb_grant_oe_n(bus.arb_grant_oe_n));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic step(input int n);
    repeat (n) @(posedge ref_clk_in);
    #1;
  endtask : step
  task automatic report_and_stop;
    $display("checks=%0d fails=%0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : report_and_stop
  initial begin
    {want, act, vec, clr_en, strobe, fail, bclr, pf, iack_in} = 9'h000;
    {arb_en, ror_en, ext_req} = 6'h00;
    grant = 4'h0;
    irq = 7'h00;
    step(10);
    rst_in = 1'b0;
    step(2);
    for (e = 0; e < 16; e++) begin
      seed = lfsr(seed);
      grant = seed[3:0];
      grant[LVL] = 1'b0;
      iack_in = seed[4];
      step(2);
      `TCHK(bus.grant_out_n[(LVL + 1) % 4], ~grant[(LVL + 1) % 4])
      `TCHK(bus.grant_out_n[(LVL + 2) % 4], ~grant[(LVL + 2) % 4])
      `TCHK(bus.grant_out_n[(LVL + 3) % 4], ~grant[(LVL + 3) % 4])
      `TCHK(bus.iack_chain_out_n, ~iack_in)
    end
    grant = 4'h0;
    $display("test chains done");
    // a failed strobe answers with error only; nothing counts outside a cycle
    for (e = 0; e < 9; e++) begin
      {act, strobe, fail} = 3'(e);
      step(6);
      `TCHK(done, act & strobe & ~fail)
      `TCHK(err, act & strobe & fail)
    end
    $display("test transfers done");
    for (e = 0; e < 12; e++) begin
      seed = lfsr(seed);
      {clr_en, bclr, pf, irq} = seed[9:0];
      step(6);
      x = 0;
      for (k = 1; k < 8; k++) if (irq[k]) x = k;
      `TCHK(lvl, 3'(x))
      `TCHK(nmi, pf)
      `TCHK(clri, bclr & clr_en)
    end
    {clr_en, bclr, pf, irq} = 10'h000;
    $display("test interrupts done");
    act = 1'b1;
    vec = 1'b1;
    iack_in = 1'b1;
    step(3);
    `TCHK(bus.iack_n, 1'b0)
    `TCHK(iack_seen, 1'b1)
    vec = 1'b0;
    step(3);
    `TCHK(bus.iack_n, 1'b1)
    act = 1'b0;
    $display("test vector fetch done");
    want = 1'b1;
    `WAITC(!bus.bus_req_n[LVL])
    `TCHK(bus.bus_req_n, 4'hF & ~(4'h1 << LVL))
    grant[LVL] = 1'b1;
    `WAITC(owned)
    `TCHK(bus.busy_n, 1'b0)
    `TCHK(bus.bus_req_n[LVL], 1'b1)
    // the arbiter takes its grant back once busy is seen, so a stale
    // grant is not passed on when the bus is given back
    grant = 4'h0;
    step(2);
    `TCHK(busy_seen, 1'b1)
    want = 1'b0;
    `WAITC(!owned)
    step(3);
    `TCHK(bus.busy_n, 1'b1)
    grant[LVL] = 1'b1;
    `WAITC(!bus.grant_out_n[LVL])
    `TCHK(bus.bus_req_n[LVL], 1'b1)
    grant = 4'h0;
    `WAITC(bus.grant_out_n[LVL])
    `TCHK(owned, 1'b0)
    $display("test arbitration done");
    // another master requests level 3 from the on-board arbiter
    arb_en = 1'b1;
    ext_req = 4'h8;
    `WAITC(!bus.grant_in_n[3])
    `TCHK(bus.arb_grant_o_n, 1'b0)
    `TCHK(bus.arb_grant_oe_n, 1'b0)
    `TCHK(bus.grant_out_n[3], 1'b0)
    arb_en = 1'b0;
    ext_req = 4'h0;
    step(2);
    `TCHK(bus.arb_grant_oe_n, 1'b1)
    `TCHK(bus.grant_in_n[3], 1'b1)
    $display("test arbiter done");
    // owner gives way to a request on another level, then asks again
    ror_en = 1'b1;
    want = 1'b1;
    grant[LVL] = 1'b1;
    `WAITC(owned)
    grant = 4'h0;
    step(3);
    `TCHK(bus.busy_n, 1'b0)
    ext_req[(LVL + 1) % 4] = 1'b1;
    `WAITC(!owned)
    `TCHK(bus.busy_n, 1'b1)
    step(1);
    `TCHK(bus.bus_req_n[LVL], 1'b0)
    $display("test release on request done");
    report_and_stop();
  end
endmodule : test_backplane_master_arbitration_interrupt
